/* File: rtl/wwd_top.sv */
/*
 Window watchdog with supply-supervisor reset link: top level.
 Assumes pad inputs arrive asynchronously; the speed select pad carries an
 external pull-down. Outputs are active-low levels for open-collector pads.
*/
`timescale 1ns/1ps
`default_nettype none
module wwd_top #(
    parameter int SAM_FAST = wwd_pkg::SAM_FAST_CYC,
    parameter int SAM_SLOW = wwd_pkg::SAM_SLOW_CYC,
    parameter int RD_LEN   = wwd_pkg::RD_CYC
) (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rst_b,
    // Processor side
    input  wire logic cpu_trigger_in,
    input  wire logic timing_speed_select,
    // Supply supervision
    input  wire logic supply_below_thr_in,
    input  wire logic input_uv_in,
    // Outputs
    output logic      supervisor_reset_out_n,
    output logic      cpu_fail_out_n
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    wwd_pkg::wwd_pins_type      pins;
    wwd_pkg::wwd_pins_type      meta_ff;
    wwd_pkg::wwd_pins_type      sync_ff;

    logic [wwd_pkg::RR_CW-1:0]  rr_cnt_ff;
    logic [wwd_pkg::RR_CW-1:0]  nxt_rr_cnt;
    logic [wwd_pkg::DLY_CW-1:0] rel_cnt_ff;
    logic [wwd_pkg::DLY_CW-1:0] nxt_rel_cnt;
    logic                       reset_n_ff;
    logic                       nxt_reset_n;

    wwd_pkg::wwd_state_type     state_ff;
    wwd_pkg::wwd_state_type     nxt_state;
    logic [wwd_pkg::DLY_CW-1:0] dly_cnt_ff;
    logic [wwd_pkg::DLY_CW-1:0] nxt_dly_cnt;
    logic [wwd_pkg::WIN_CW-1:0] win_cnt_ff;
    logic [wwd_pkg::WIN_CW-1:0] nxt_win_cnt;
    logic                       mode_slow_ff;
    logic                       nxt_mode_slow;
    logic                       fail_n_ff;
    logic                       nxt_fail_n;

    logic                       smp_restart;
    logic                       smp_clear;
    logic                       tick;
    logic                       trig_valid;
    logic [wwd_pkg::WIN_CW-1:0] iw_last;
    logic [wwd_pkg::WIN_CW-1:0] tw_last;

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    always_comb begin
        pins.input_uv     = input_uv_in;
        pins.supply_below = supply_below_thr_in;
        pins.speed_sel    = timing_speed_select;
        pins.trigger      = cpu_trigger_in;
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= pins;
            sync_ff <= meta_ff;
        end
    end

    // ------------------------------------------------------------------
    // Supervisor reset output
    // ------------------------------------------------------------------
    always_comb begin
        nxt_rr_cnt  = '0;
        nxt_rel_cnt = rel_cnt_ff;
        nxt_reset_n = reset_n_ff;
        if (sync_ff.supply_below && (rr_cnt_ff < wwd_pkg::RR_CW'(wwd_pkg::RR_CYC))) begin
            nxt_rr_cnt = rr_cnt_ff + 1'b1;
        end else if (sync_ff.supply_below) begin
            nxt_rr_cnt = rr_cnt_ff;
        end
        if (sync_ff.input_uv) begin
            nxt_reset_n = 1'b0;
            nxt_rel_cnt = '0;
        end else if (sync_ff.supply_below) begin
            nxt_rel_cnt = '0;
            if (rr_cnt_ff >= wwd_pkg::RR_CW'(wwd_pkg::RR_CYC)) begin
                nxt_reset_n = 1'b0;
            end
        end else if (!reset_n_ff) begin
            if (rel_cnt_ff >= wwd_pkg::DLY_CW'(RD_LEN - 1)) begin
                nxt_reset_n = 1'b1;
                nxt_rel_cnt = '0;
            end else begin
                nxt_rel_cnt = rel_cnt_ff + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rr_cnt_ff  <= '0;
            rel_cnt_ff <= '0;
            reset_n_ff <= 1'b0;
        end else begin
            rr_cnt_ff  <= nxt_rr_cnt;
            rel_cnt_ff <= nxt_rel_cnt;
            reset_n_ff <= nxt_reset_n;
        end
    end

    // ------------------------------------------------------------------
    // Sampling tick and trigger qualification
    // ------------------------------------------------------------------
    wwd_sampler #(
        .SAM_FAST (SAM_FAST),
        .SAM_SLOW (SAM_SLOW)
    ) u_sampler (
        .clk_sys    (clk_sys),
        .rst_b      (rst_b),
        .restart    (smp_restart),
        .clear      (smp_clear),
        .slow       (mode_slow_ff),
        .trig_level (sync_ff.trigger),
        .tick       (tick),
        .trig_valid (trig_valid)
    );

    // ------------------------------------------------------------------
    // Watchdog window sequencer
    // ------------------------------------------------------------------
    always_comb begin
        iw_last       = mode_slow_ff ? wwd_pkg::WIN_CW'(wwd_pkg::IW_SLOW_TICKS - 1)
                                     : wwd_pkg::WIN_CW'(wwd_pkg::IW_FAST_TICKS - 1);
        tw_last       = mode_slow_ff ? wwd_pkg::WIN_CW'(wwd_pkg::TW_SLOW_TICKS - 1)
                                     : wwd_pkg::WIN_CW'(wwd_pkg::TW_FAST_TICKS - 1);
        nxt_state     = state_ff;
        nxt_dly_cnt   = dly_cnt_ff;
        nxt_win_cnt   = win_cnt_ff;
        nxt_mode_slow = mode_slow_ff;
        smp_restart   = 1'b1;
        smp_clear     = 1'b0;
        unique case (state_ff)
            wwd_pkg::ST_RST_HOLD: begin
                nxt_dly_cnt = '0;
                if (reset_n_ff) begin
                    nxt_state = wwd_pkg::ST_FAIL_HOLD;
                end
            end
            wwd_pkg::ST_FAIL_HOLD: begin
                if (dly_cnt_ff >= wwd_pkg::DLY_CW'(RD_LEN - 1)) begin
                    nxt_state     = wwd_pkg::ST_IGNORE;
                    nxt_dly_cnt   = '0;
                    nxt_win_cnt   = '0;
                    nxt_mode_slow = sync_ff.speed_sel;
                end else begin
                    nxt_dly_cnt = dly_cnt_ff + 1'b1;
                end
            end
            wwd_pkg::ST_IGNORE: begin
                smp_restart = 1'b0;
                smp_clear   = 1'b1;
                if (tick) begin
                    if (win_cnt_ff >= iw_last) begin
                        nxt_state     = wwd_pkg::ST_WINDOW;
                        nxt_win_cnt   = '0;
                        nxt_mode_slow = sync_ff.speed_sel;
                    end else begin
                        nxt_win_cnt = win_cnt_ff + 1'b1;
                    end
                end
            end
            wwd_pkg::ST_WINDOW: begin
                smp_restart = 1'b0;
                if (trig_valid) begin
                    nxt_state   = wwd_pkg::ST_GAP;
                    nxt_win_cnt = '0;
                    smp_clear   = 1'b1;
                end else if (tick) begin
                    if (win_cnt_ff >= tw_last) begin
                        nxt_state   = wwd_pkg::ST_FAIL_HOLD;
                        nxt_dly_cnt = '0;
                    end else begin
                        nxt_win_cnt = win_cnt_ff + 1'b1;
                    end
                end
            end
            wwd_pkg::ST_GAP: begin
                smp_restart = 1'b0;
                smp_clear   = 1'b1;
                if (tick) begin
                    nxt_state     = wwd_pkg::ST_WINDOW;
                    nxt_win_cnt   = '0;
                    nxt_mode_slow = sync_ff.speed_sel;
                end
            end
            default: begin
                nxt_state = wwd_pkg::ST_RST_HOLD;
            end
        endcase
        if (!reset_n_ff) begin
            nxt_state   = wwd_pkg::ST_RST_HOLD;
            nxt_dly_cnt = '0;
            nxt_win_cnt = '0;
        end
        nxt_fail_n = nxt_reset_n && ((nxt_state == wwd_pkg::ST_IGNORE) || (nxt_state == wwd_pkg::ST_WINDOW)
                                      || (nxt_state == wwd_pkg::ST_GAP));
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state_ff     <= wwd_pkg::ST_RST_HOLD;
            dly_cnt_ff   <= '0;
            win_cnt_ff   <= '0;
            mode_slow_ff <= wwd_pkg::MODE_RST;
            fail_n_ff    <= 1'b0;
        end else begin
            state_ff     <= nxt_state;
            dly_cnt_ff   <= nxt_dly_cnt;
            win_cnt_ff   <= nxt_win_cnt;
            mode_slow_ff <= nxt_mode_slow;
            fail_n_ff    <= nxt_fail_n;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign supervisor_reset_out_n = reset_n_ff;
    assign cpu_fail_out_n         = fail_n_ff;

endmodule
`default_nettype wire

/* File: rtl/wwd_pkg.sv */
/*
 Constants, types and state codes for the window watchdog with reset link.
 Assumes a 10 MHz system clock; timing is counted in clk_sys cycles, window lengths in sampling ticks.
*/
package wwd_pkg;

    // ------------------------------------------------------------------
    // Time figures and derived cycle counts
    // ------------------------------------------------------------------
    localparam int T_CLK_NS       = 100;
    localparam int T_SAM_FAST_US  = 500;
    localparam int T_SAM_SLOW_US  = 1000;
    localparam int T_IW_FAST_US   = 32000;
    localparam int T_IW_SLOW_US   = 64000;
    localparam int T_WDP_FAST_US  = 32000;
    localparam int T_WDP_SLOW_US  = 64000;
    localparam int T_RD_US        = 8000;
    localparam int T_RR_NS        = 10000;

    localparam int SAM_FAST_CYC   = (T_SAM_FAST_US * 1000) / T_CLK_NS;
    localparam int SAM_SLOW_CYC   = (T_SAM_SLOW_US * 1000) / T_CLK_NS;
    localparam int RD_CYC         = (T_RD_US * 1000) / T_CLK_NS;
    localparam int RR_CYC         = T_RR_NS / T_CLK_NS;

    // Window lengths in sampling ticks
    localparam int IW_FAST_TICKS  = T_IW_FAST_US / T_SAM_FAST_US;
    localparam int IW_SLOW_TICKS  = T_IW_SLOW_US / T_SAM_SLOW_US;
    localparam int TW_FAST_TICKS  = T_WDP_FAST_US / T_SAM_FAST_US - 1;
    localparam int TW_SLOW_TICKS  = T_WDP_SLOW_US / T_SAM_SLOW_US - 1;

    // ------------------------------------------------------------------
    // Counter widths and reset values
    // ------------------------------------------------------------------
    localparam int SAM_CW         = 14;
    localparam int WIN_CW         = 7;
    localparam int DLY_CW         = 17;
    localparam int RR_CW          = 7;
    localparam logic [3:0] HIST_RST     = 4'h0;
    localparam logic [3:0] HIST_TRIGGER = 4'hc;
    localparam logic       MODE_RST     = 1'b0;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic input_uv;
        logic supply_below;
        logic speed_sel;
        logic trigger;
    } wwd_pins_type;

    typedef enum logic [4:0] {
        ST_RST_HOLD  = 5'h01,
        ST_FAIL_HOLD = 5'h02,
        ST_IGNORE    = 5'h04,
        ST_WINDOW    = 5'h08,
        ST_GAP       = 5'h10
    } wwd_state_type;

endpackage

/* File: rtl/wwd_sampler.sv */
/*
 Sampling tick generator and trigger edge qualifier.
 Assumes a synchronised trigger level and a mode held stable by the caller.
*/
`timescale 1ns/1ps
`default_nettype none
module wwd_sampler #(
    parameter int SAM_FAST = wwd_pkg::SAM_FAST_CYC,
    parameter int SAM_SLOW = wwd_pkg::SAM_SLOW_CYC
) (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rst_b,
    // Control
    input  wire logic restart,
    input  wire logic clear,
    input  wire logic slow,
    input  wire logic trig_level,
    // Results
    output logic      tick,
    output logic      trig_valid
);

    logic [wwd_pkg::SAM_CW-1:0] cnt_ff;
    logic [wwd_pkg::SAM_CW-1:0] nxt_cnt;
    logic [wwd_pkg::SAM_CW-1:0] limit;
    logic [3:0]                 hist_ff;
    logic [3:0]                 nxt_hist;
    logic                       tick_ff;
    logic                       nxt_tick;
    logic                       trig_ff;
    logic                       nxt_trig;

    // ------------------------------------------------------------------
    // Tick counter and sample history
    // ------------------------------------------------------------------
    always_comb begin
        limit    = slow ? wwd_pkg::SAM_CW'(SAM_SLOW - 1) : wwd_pkg::SAM_CW'(SAM_FAST - 1);
        nxt_cnt  = cnt_ff + 1'b1;
        nxt_tick = 1'b0;
        nxt_hist = hist_ff;
        nxt_trig = 1'b0;
        if (cnt_ff >= limit) begin
            nxt_cnt  = '0;
            nxt_tick = 1'b1;
            nxt_hist = {hist_ff[2:0], trig_level};
            nxt_trig = ({hist_ff[2:0], trig_level} == wwd_pkg::HIST_TRIGGER);
        end
        if (restart) begin
            nxt_cnt  = '0;
            nxt_tick = 1'b0;
            nxt_trig = 1'b0;
        end
        if (clear || restart) begin
            nxt_hist = wwd_pkg::HIST_RST;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cnt_ff  <= '0;
            hist_ff <= wwd_pkg::HIST_RST;
            tick_ff <= 1'b0;
            trig_ff <= 1'b0;
        end else begin
            cnt_ff  <= nxt_cnt;
            hist_ff <= nxt_hist;
            tick_ff <= nxt_tick;
            trig_ff <= nxt_trig;
        end
    end

    assign tick       = tick_ff;
    assign trig_valid = trig_ff;

endmodule
`default_nettype wire

/* File: dv/wwd_cpu_model.sv */
/*
 Processor model that toggles the watchdog trigger pin.
 Assumes the bench enables it only when triggering is wanted.
*/
`timescale 1ns/1ps
`default_nettype none
module wwd_cpu_model (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    // Control
    input  wire logic        enable,
    input  wire logic [15:0] half_cycles,
    // Pin
    output logic             cpu_trigger_in
);
    logic [15:0] cnt_ff;
    logic [15:0] nxt_cnt;
    logic        lvl_ff;
    logic        nxt_lvl;

    // Steady toggling well inside every window; pin rests low when idle
    always_comb begin
        nxt_cnt = cnt_ff + 16'h0001;
        nxt_lvl = lvl_ff;
        if (!enable) begin
            nxt_cnt = 16'h0000;
            nxt_lvl = 1'b0;
        end else if (cnt_ff >= half_cycles - 16'h0001) begin
            nxt_cnt = 16'h0000;
            nxt_lvl = !lvl_ff;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cnt_ff <= 16'h0000;
            lvl_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            lvl_ff <= nxt_lvl;
        end
    end

    assign cpu_trigger_in = lvl_ff;
endmodule
`default_nettype wire

/* File: dv/wwd_top_sva.sv */
/*
 Concurrent checks on the watchdog top level.
 Assumes it is bound into wwd_top and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module wwd_top_sva #(
    parameter int SAM_FAST = 10,
    parameter int SAM_SLOW = 20,
    parameter int RD_LEN   = 50
) (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rst_b,
    // Inputs
    input  wire logic cpu_trigger_in,
    input  wire logic timing_speed_select,
    input  wire logic supply_below_thr_in,
    input  wire logic input_uv_in,
    // Outputs
    input  wire logic supervisor_reset_out_n,
    input  wire logic cpu_fail_out_n
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    // ------------------------------------------------------------------
    // Helper counters
    // ------------------------------------------------------------------
    int below_cnt_ff;
    int quiet_cnt_ff;
    int low_cnt_ff;
    int since_rise_ff;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            below_cnt_ff  <= 0;
            quiet_cnt_ff  <= 0;
            low_cnt_ff    <= 0;
            since_rise_ff <= 0;
        end else begin
            below_cnt_ff  <= supply_below_thr_in ? below_cnt_ff + 1 : 0;
            quiet_cnt_ff  <= (input_uv_in || supply_below_thr_in) ? 0 : quiet_cnt_ff + 1;
            low_cnt_ff    <= (cpu_fail_out_n || !supervisor_reset_out_n) ? 0 : low_cnt_ff + 1;
            since_rise_ff <= cpu_fail_out_n ? since_rise_ff + 1 : 0;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence s_uv_held;
        input_uv_in [*4];
    endsequence

    sequence s_watch_miss;
        $fell(cpu_fail_out_n) ##0 supervisor_reset_out_n;
    endsequence

    reset_forces_fail_a: assert property (!supervisor_reset_out_n |-> !cpu_fail_out_n)
        else $error("failure output high while reset output low");
    uv_reset_a: assert property (s_uv_held |=> !supervisor_reset_out_n)
        else $error("undervoltage did not pull reset low");
    glitch_filter_a: assert property ($fell(supervisor_reset_out_n) |->
        ($past(input_uv_in, 3) || $past(input_uv_in, 4) || below_cnt_ff >= wwd_pkg::RR_CYC))
        else $error("reset fell without a lasting fault");
    reset_hold_a: assert property ($rose(supervisor_reset_out_n) |-> quiet_cnt_ff >= RD_LEN - 2)
        else $error("reset rose before the delay ran out");
    reset_release_a: assert property (quiet_cnt_ff >= RD_LEN + 6 |-> supervisor_reset_out_n)
        else $error("reset stayed low after the delay");
    fail_hold_a: assert property ($rose(cpu_fail_out_n) |->
        (low_cnt_ff >= RD_LEN - 2 && low_cnt_ff <= RD_LEN + 3))
        else $error("failure low time differs from the reset delay");
    ignore_min_a: assert property (s_watch_miss |-> since_rise_ff >= 126 * SAM_FAST)
        else $error("failure reported before ignore and trigger windows ran out");
    reset_indep_a: assert property (s_watch_miss ##0 (!input_uv_in && !supply_below_thr_in)
        |=> supervisor_reset_out_n)
        else $error("watchdog failure disturbed the reset output");
endmodule

bind wwd_top wwd_top_sva #(.SAM_FAST(SAM_FAST), .SAM_SLOW(SAM_SLOW), .RD_LEN(RD_LEN)) i_wwd_top_sva (
    .clk_sys(clk_sys), .rst_b(rst_b), .cpu_trigger_in(cpu_trigger_in),
    .timing_speed_select(timing_speed_select), .supply_below_thr_in(supply_below_thr_in),
    .input_uv_in(input_uv_in), .supervisor_reset_out_n(supervisor_reset_out_n),
    .cpu_fail_out_n(cpu_fail_out_n));
`default_nettype wire

/* File: dv/wwd_top_tb_top.sv */
/*
 Self-checking bench for the window watchdog top level.
 Assumes shortened timing parameters and the processor model as partner.
*/
`timescale 1ns/1ps
`default_nettype none
module wwd_top_tb_top;
    localparam int SF = 10;
    localparam int SS = 20;
    localparam int RD = 50;

    logic        clk_sys = 1'b0;
    logic        rst_b = 1'b0;
    logic        spd = 1'b0;
    logic        below = 1'b0;
    logic        uv = 1'b0;
    logic        trig_en = 1'b0;
    logic        trig;
    logic        rst_out_n;
    logic        fail_n;
    int          n_errors = 0;
    int          n_tests = 0;

    initial forever #50 clk_sys = !clk_sys;

    wwd_cpu_model i_wwd_cpu_model (.clk_sys(clk_sys), .rst_b(rst_b), .enable(trig_en),
        .half_cycles(16'h003c), .cpu_trigger_in(trig));
    wwd_top #(.SAM_FAST(SF), .SAM_SLOW(SS), .RD_LEN(RD)) i_wwd_top (.clk_sys(clk_sys), .rst_b(rst_b),
        .cpu_trigger_in(trig), .timing_speed_select(spd), .supply_below_thr_in(below),
        .input_uv_in(uv), .supervisor_reset_out_n(rst_out_n), .cpu_fail_out_n(fail_n));

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic end_of_test();
        if (n_errors == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check_bit(input string name, input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %0b seen %0b", name, exp, got);
        end
    endtask

    task automatic check_range(input string name, input int lo, input int hi, input int got);
        n_tests++;
        if (got < lo || got > hi) begin
            n_errors++;
            $display("Error %s expected %0d to %0d seen %0d", name, lo, hi, got);
        end
    endtask

    // Counts negedges until the chosen output shows the level
    task automatic wait_for(input bit use_fail, input logic lvl, input int bound, output int n);
        n = 0;
        while (((use_fail ? fail_n : rst_out_n) !== lvl) && n < bound) begin
            @(negedge clk_sys);
            n++;
        end
        if (n >= bound) begin
            n_errors++;
            $display("Error wait expected %0b seen timeout", lvl);
            end_of_test();
        end
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_power_up();
        int n;
        wait_for(0, 1'b1, RD + 20, n);
        check_range("reset_delay", RD - 1, RD + 5, n);
        check_bit("fail_at_reset_rise", 1'b0, fail_n);
        wait_for(1, 1'b1, RD + 20, n);
        check_range("fail_delay", RD - 1, RD + 4, n);
    endtask

    task automatic t_miss(input logic slow, input int sam, input bit ignore_trig);
        int n;
        if (ignore_trig) begin
            @(posedge clk_sys) trig_en <= 1'b1;
            repeat (300) @(posedge clk_sys);
            trig_en <= 1'b0;
        end
        wait_for(1, 1'b0, 130 * sam, n);
        check_range("miss_time", 126 * sam - (ignore_trig ? 301 : 0), 128 * sam + 5, n);
        check_bit("reset_after_miss", 1'b1, rst_out_n);
        wait_for(1, 1'b1, RD + 20, n);
        check_range("miss_low_time", RD - 2, RD + 3, n);
    endtask

    task automatic t_trigger();
        int bad;
        bad = 0;
        @(posedge clk_sys) trig_en <= 1'b1;
        for (int i = 0; i < 9000; i++) begin
            if (i == 3000) begin
                @(posedge clk_sys) spd <= 1'b1;
            end
            @(negedge clk_sys);
            if (fail_n !== 1'b1) begin
                bad++;
            end
        end
        check_range("fail_low_while_triggered", 0, 0, bad);
        @(posedge clk_sys) trig_en <= 1'b0;
        // Miss while mid-window: at most one gap plus two slow windows away
        wait_for(1, 1'b0, 130 * SS, bad);
        check_range("slow_first_miss", 1, 130 * SS, bad);
        check_bit("reset_after_slow_miss", 1'b1, rst_out_n);
        wait_for(1, 1'b1, RD + 20, bad);
        check_range("slow_miss_low_time", RD - 2, RD + 3, bad);
        wait_for(1, 1'b0, 130 * SS, bad);
        check_range("slow_miss_time", 126 * SS, 128 * SS + 5, bad);
        @(posedge clk_sys) spd <= 1'b0;
        wait_for(1, 1'b1, RD + 20, bad);
    endtask

    task automatic t_uv();
        int n;
        @(posedge clk_sys) uv <= 1'b1;
        wait_for(0, 1'b0, 10, n);
        check_range("uv_reaction", 1, 4, n);
        check_bit("fail_with_uv", 1'b0, fail_n);
        repeat (20) @(posedge clk_sys);
        uv <= 1'b0;
        t_power_up();
    endtask

    task automatic t_glitch();
        int n;
        @(posedge clk_sys) below <= 1'b1;
        repeat (50) @(posedge clk_sys);
        below <= 1'b0;
        repeat (10) @(negedge clk_sys);
        check_bit("reset_after_glitch", 1'b1, rst_out_n);
        @(posedge clk_sys) below <= 1'b1;
        wait_for(0, 1'b0, 150, n);
        check_range("reaction_time", 100, 106, n);
        check_bit("fail_with_below", 1'b0, fail_n);
        @(posedge clk_sys) below <= 1'b0;
        t_power_up();
    endtask

    initial begin
        repeat (3) @(posedge clk_sys);
        rst_b <= 1'b1;
        t_power_up();
        t_miss(1'b0, SF, 1'b1);
        t_trigger();
        t_uv();
        t_glitch();
        end_of_test();
    end
endmodule
`default_nettype wire
